// ===== shared/lcd_host_pkg.sv
package lcd_host_pkg;
	// ---------------------------------------------------------------
	// register bus
	// ---------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_ROW_CYCLES = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_COMMAND = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_READ_DATA = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// field layout
	// ---------------------------------------------------------------
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_STRAP_BIT = 4;
	localparam int CMD_RS_BIT = 16;
	localparam int CMD_READ_BIT = 17;
	localparam int CMD_RAM_BIT = 18;
	localparam int CMD_PACE_BIT = 19;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_OPEN_BIT = 1;
	localparam logic [15:0] ROW_CYCLES_RST = 16'h0FDC;

	// ---------------------------------------------------------------
	// link layout
	// ---------------------------------------------------------------
	localparam int DB_W = 18;
	localparam int BYTE_W = 8;
	localparam logic [2:0] DUMMY_RAM = 3'h4;
	localparam logic [2:0] DUMMY_REG = 3'h2;
	localparam logic [2:0] DATA_BYTES = 3'h2;
	localparam logic [2:0] SERIAL_MODE = 3'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 50;
	localparam int HOLD_NS = 20;
	localparam int SCLK_HALF_NS = 100;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] SETUP_LAST = 8'(SETUP_CYC - 1);
	localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);
	localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
	localparam logic [7:0] SCLK_HALF_LAST = 8'(SCLK_HALF_CYC - 1);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETUP = 5'h02,
		ST_STROBE = 5'h04,
		ST_HOLD = 5'h08,
		ST_SER = 5'h10
	} host_state_t;
endpackage : lcd_host_pkg

// ===== rtl/lcd_serial_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_serial_shifter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [lcd_host_pkg::BYTE_W-1:0] tx_byte,
	input wire logic sdo_sync,
	output logic done,
	output logic [lcd_host_pkg::BYTE_W-1:0] rx_byte,
	output logic serial_clock,
	output logic serial_data_in
);
	import lcd_host_pkg::*;

	typedef struct packed {
		logic busy;
		logic [2:0] bitn;
		logic [7:0] div;
		logic sclk;
		logic [BYTE_W-1:0] tx;
		logic [BYTE_W-1:0] rx;
		logic done;
	} shift_t;

	localparam shift_t SHIFT_RST = '{sclk: 1'b1, default: '0};

	shift_t s;
	shift_t next_s;

	// ---------------------------------------------------------------
	// one byte, msb first; clock idles high, device samples rising edge
	// ---------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (!s.busy) begin
			if (start) begin
				next_s.busy = 1'b1;
				next_s.bitn = 3'h0;
				next_s.div = 8'h00;
				next_s.tx = tx_byte;
				next_s.sclk = 1'b0;
			end
		end else if (s.div != SCLK_HALF_LAST) begin
			next_s.div = s.div + 8'h01;
		end else begin
			next_s.div = 8'h00;
			if (!s.sclk) begin
				next_s.sclk = 1'b1;
			end else begin
				// sampled late in the high phase so the two sync stages have settled
				next_s.rx = {s.rx[BYTE_W-2:0], sdo_sync}; // R13
				if (s.bitn == 3'h7) begin
					// last bit stays on the pin: the clock is still high here
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end else begin
					next_s.tx = {s.tx[BYTE_W-2:0], 1'b0}; // R13
					next_s.bitn = s.bitn + 3'h1;
					next_s.sclk = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= SHIFT_RST;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
	assign rx_byte = s.rx;
	assign serial_clock = s.sclk;
	assign serial_data_in = s.tx[BYTE_W-1];
endmodule : lcd_serial_shifter
`default_nettype wire

// ===== rtl/lcd_host_ctrl.sv
// Behaviour
// R1: all-low 68 16-bit, bit1 80 16-bit
// R2: 1001 68 9-bit, 1011 80 9-bit
// R3: 9-bit splits word, upper part first
// R4: 0001 68 8-bit, 0011 80 8-bit
// R5: 8-bit splits word, upper byte first
// R6: index writes also send both parts
// R7: serial uses select, clock, two data lines
// R8: transaction framed by chip select low
// R9: start byte carries six-bit chip address
// R10: address lsb from strap, five fixed bits
// R11: start byte bit seven is register select
// R12: start byte bit eight is direction
// R13: bytes move msb first after start byte
// R14: instruction upper byte then lower byte
// R15: ram read skips four dummy bytes
// R16: status/instruction read skips two bytes
// R17: frame-sync mode set by device registers
// R18: device scans from oscillator and sync
// R19: device resets write address on sync
// R20: wait two rows after sync fall
// R21: host pixel rate must exceed budget
// R22: each raster row is sixteen oscillator clocks
// R23: registers set only over system interface
// R24: mode switch waits for frame end
// R25: address mismatch ignores rest of transaction
// R26: device commits word after second part
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_ctrl #(
	parameter logic [4:0] DEVICE_CODE = 5'h15, // arbitrary value
	parameter logic [15:0] ROW_CYCLES_INIT = lcd_host_pkg::ROW_CYCLES_RST
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [lcd_host_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [lcd_host_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [lcd_host_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [lcd_host_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [2:0] interface_mode_pins,
	output logic mode_lsb_or_strap_pin,
	output logic chip_select_n,
	output logic register_select,
	output logic write_n,
	output logic read_n,
	output logic enable,
	output logic read_not_write,
	output logic [lcd_host_pkg::DB_W-1:0] data_bus_out,
	output logic data_bus_oe,
	input wire logic [lcd_host_pkg::DB_W-1:0] data_bus_in,
	output logic serial_clock,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic frame_sync
);
	import lcd_host_pkg::*;

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// the read sample point needs the bus sync delay inside the strobe
	if (STROBE_CYC < 3 || STROBE_CYC > 255 || SETUP_CYC > 255 || HOLD_CYC > 255) begin : g_bad_timing
		$error("strobe timing out of range");
	end
	if (SCLK_HALF_CYC < 3 || SCLK_HALF_CYC > 255) begin : g_bad_sclk
		$error("serial clock half period out of range");
	end
	if (ROW_CYCLES_INIT == 16'h0000) begin : g_bad_row
		$error("row period must be nonzero");
	end

	// ---------------------------------------------------------------
	// mode decode
	// ---------------------------------------------------------------
	function automatic logic is_serial(input logic [3:0] m);
		return m[3:1] == SERIAL_MODE; // R7
	endfunction : is_serial

	function automatic logic is_split(input logic [3:0] m);
		return m[0] && !is_serial(m); // R3 R5
	endfunction : is_split

	function automatic logic is_80(input logic [3:0] m);
		return m[1]; // R1 R2 R4
	endfunction : is_80

	function automatic logic [DB_W-1:0] bus_word(input logic [15:0] d, input logic [3:0] m,
			input logic beat);
		if (is_split(m)) begin
			return {(beat ? d[7:0] : d[15:8]), 10'h000}; // R3 R5
		end
		return {d[15:8], 1'b0, d[7:0], 1'b0}; // R1
	endfunction : bus_word

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] nw, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] cfg_mode;
		logic cfg_strap;
		logic [15:0] row_cycles;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		host_state_t st;
		logic pend;
		logic [15:0] cmd_data;
		logic cmd_rs;
		logic cmd_read;
		logic cmd_ram;
		logic cmd_pace;
		logic beat;
		logic [2:0] bytes_left;
		logic [7:0] cnt;
		logic [15:0] read_word;
		logic cs_n;
		logic rs;
		logic wr_n;
		logic rd_n;
		logic en;
		logic rnw;
		logic [DB_W-1:0] dout;
		logic doe;
		logic ser_start;
		logic [BYTE_W-1:0] ser_tx;
		logic fs_s1;
		logic fs_s2;
		logic fs_prev;
		logic sdo_s1;
		logic sdo_s2;
		logic [DB_W-1:0] db_s1;
		logic [DB_W-1:0] db_s2;
		logic [16:0] win_cnt;
		logic win_open;
	} ctrl_t;

	localparam ctrl_t CTRL_RST = '{
		row_cycles: ROW_CYCLES_INIT,
		st: ST_IDLE,
		cs_n: 1'b1,
		wr_n: 1'b1,
		rd_n: 1'b1,
		rnw: 1'b1,
		win_open: 1'b1,
		default: '0
	};

	ctrl_t s;
	ctrl_t next_s;
	logic ser_done;
	logic [BYTE_W-1:0] ser_rx;
	logic busy;
	logic [16:0] win_len;

	assign busy = s.pend || (s.st != ST_IDLE);
	assign win_len = {s.row_cycles, 1'b0};

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ser_start = 1'b0;

		// pin synchronisers
		next_s.fs_s1 = frame_sync;
		next_s.fs_s2 = s.fs_s1;
		next_s.fs_prev = s.fs_s2;
		next_s.sdo_s1 = serial_data_out;
		next_s.sdo_s2 = s.sdo_s1;
		next_s.db_s1 = data_bus_in;
		next_s.db_s2 = s.db_s1;

		// write window: closed at each sync fall until two rows pass
		if (s.fs_prev && !s.fs_s2) begin
			next_s.win_open = 1'b0; // R20
			next_s.win_cnt = 17'h00000;
		end else if (!s.win_open) begin
			if (s.win_cnt >= win_len - 17'h00001) begin
				next_s.win_open = 1'b1; // R20
			end else begin
				next_s.win_cnt = s.win_cnt + 17'h00001;
			end
		end

		// register bus: address and data taken in either order
		if (awvalid && !s.aw_held) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && !s.w_held) begin
			next_s.w_held = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			unique case (s.aw_addr)
				OFF_CONFIG: begin
					{next_s.cfg_strap, next_s.cfg_mode} =
						5'(merge(DATA_W'({s.cfg_strap, s.cfg_mode}), s.w_data, s.w_strb));
				end
				OFF_ROW_CYCLES: begin
					next_s.row_cycles = 16'(merge(DATA_W'(s.row_cycles), s.w_data, s.w_strb));
				end
				OFF_COMMAND: begin
					// a command written while busy is dropped; software polls busy first
					if (!busy) begin
						next_s.pend = 1'b1;
						next_s.cmd_data = s.w_data[15:0];
						next_s.cmd_rs = s.w_data[CMD_RS_BIT];
						next_s.cmd_read = s.w_data[CMD_READ_BIT];
						next_s.cmd_ram = s.w_data[CMD_RAM_BIT];
						next_s.cmd_pace = s.w_data[CMD_PACE_BIT];
					end
				end
				OFF_STATUS, OFF_READ_DATA: begin
				end
				default: begin
					next_s.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = '0;
			unique case (araddr)
				OFF_CONFIG: next_s.rdata = DATA_W'({s.cfg_strap, s.cfg_mode});
				OFF_ROW_CYCLES: next_s.rdata = DATA_W'(s.row_cycles);
				OFF_COMMAND: begin
				end
				OFF_STATUS: begin
					next_s.rdata[ST_BUSY_BIT] = busy;
					next_s.rdata[ST_OPEN_BIT] = s.win_open;
				end
				OFF_READ_DATA: next_s.rdata = DATA_W'(s.read_word);
				default: next_s.rresp = RESP_SLVERR;
			endcase
		end

		// link sequencer
		next_s.cnt = s.cnt + 8'h01;
		unique case (s.st)
			ST_IDLE: begin
				// paced commands hold off until the write window opens
				if (s.pend && (!s.cmd_pace || s.win_open)) begin // R20 R21
					next_s.pend = 1'b0;
					next_s.cs_n = 1'b0; // R8
					next_s.rs = s.cmd_rs;
					next_s.cnt = 8'h00;
					next_s.beat = 1'b0;
					if (is_serial(s.cfg_mode)) begin
						next_s.ser_start = 1'b1;
						next_s.ser_tx = {DEVICE_CODE, s.cfg_strap, s.cmd_rs, s.cmd_read}; // R9 R10 R11 R12
						next_s.bytes_left = !s.cmd_read ? DATA_BYTES : // R14
							(s.cmd_ram ? DUMMY_RAM : DUMMY_REG) + DATA_BYTES; // R15 R16
						next_s.st = ST_SER;
					end else begin
						next_s.rnw = s.cmd_read;
						next_s.doe = !s.cmd_read;
						next_s.dout = bus_word(s.cmd_data, s.cfg_mode, 1'b0); // R6
						next_s.st = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				if (s.cnt == SETUP_LAST) begin
					next_s.cnt = 8'h00;
					if (is_80(s.cfg_mode)) begin
						next_s.wr_n = s.cmd_read;
						next_s.rd_n = !s.cmd_read;
					end else begin
						next_s.en = 1'b1;
					end
					next_s.st = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (s.cnt == STROBE_LAST) begin
					next_s.cnt = 8'h00;
					if (s.cmd_read) begin
						if (!is_split(s.cfg_mode)) begin
							next_s.read_word = {s.db_s2[17:10], s.db_s2[8:1]};
						end else if (!s.beat) begin
							next_s.read_word[15:8] = s.db_s2[17:10]; // R3 R5
						end else begin
							next_s.read_word[7:0] = s.db_s2[17:10];
						end
					end
					next_s.wr_n = 1'b1;
					next_s.rd_n = 1'b1;
					next_s.en = 1'b0;
					next_s.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (s.cnt == HOLD_LAST) begin
					next_s.cnt = 8'h00;
					if (is_split(s.cfg_mode) && !s.beat) begin
						next_s.beat = 1'b1; // R3 R5 R6
						next_s.dout = bus_word(s.cmd_data, s.cfg_mode, 1'b1);
						next_s.st = ST_SETUP;
					end else begin
						next_s.cs_n = 1'b1;
						next_s.doe = 1'b0;
						next_s.rnw = 1'b1;
						next_s.st = ST_IDLE;
					end
				end
			end
			ST_SER: begin
				if (ser_done) begin
					// dummies shift through; the last two bytes stay in the word
					if (s.cmd_read) begin
						next_s.read_word = {s.read_word[7:0], ser_rx}; // R15 R16
					end
					if (s.bytes_left == 3'h0) begin
						next_s.cs_n = 1'b1; // R8
						next_s.st = ST_IDLE;
					end else begin
						next_s.bytes_left = s.bytes_left - 3'h1;
						next_s.ser_start = 1'b1;
						next_s.ser_tx = s.cmd_read ? 8'h00 :
							(s.bytes_left == DATA_BYTES ? s.cmd_data[15:8] : s.cmd_data[7:0]); // R14
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// serial link
	// ---------------------------------------------------------------
	lcd_serial_shifter u_shifter (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(s.ser_start),
		.tx_byte(s.ser_tx),
		.sdo_sync(s.sdo_s2),
		.done(ser_done),
		.rx_byte(ser_rx),
		.serial_clock(serial_clock),
		.serial_data_in(serial_data_in)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign awready = !s.aw_held;
	assign wready = !s.w_held;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign interface_mode_pins = s.cfg_mode[3:1];
	assign mode_lsb_or_strap_pin = is_serial(s.cfg_mode) ? s.cfg_strap : s.cfg_mode[0]; // R7 R10
	assign chip_select_n = s.cs_n;
	assign register_select = s.rs;
	assign write_n = s.wr_n;
	assign read_n = s.rd_n;
	assign enable = s.en;
	assign read_not_write = s.rnw;
	assign data_bus_out = s.dout;
	assign data_bus_oe = s.doe;
endmodule : lcd_host_ctrl
`default_nettype wire

// ===== testbench/lcd_host_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_host_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] interface_mode_pins,
	input wire logic mode_lsb_or_strap_pin,
	input wire logic chip_select_n,
	input wire logic write_n,
	input wire logic enable,
	input wire logic [lcd_host_pkg::DB_W-1:0] data_bus_out,
	input wire logic data_bus_oe,
	input wire logic serial_clock,
	input wire logic serial_data_in
);
	import lcd_host_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// -------------------------------------------------------------
	// strobe shapes
	// -------------------------------------------------------------
	sequence s_wlow; !write_n [*4] ##1 write_n; endsequence
	sequence s_ehigh; enable [*4] ##1 !enable; endsequence
	property p_wstrobe; $fell(write_n) |=> s_wlow; endproperty
	a_wstrobe: assert property (p_wstrobe) else $error("write strobe width");
	property p_estrobe; $rose(enable) |=> s_ehigh; endproperty
	a_estrobe: assert property (p_estrobe) else $error("enable strobe width");
	// data must not move under the strobe or in the hold that follows
	property p_whold; $fell(write_n) |=> $stable(data_bus_out) [*6]; endproperty
	a_whold: assert property (p_whold) else $error("data moved in write");
	property p_oe; !write_n |-> data_bus_oe && !chip_select_n; endproperty
	a_oe: assert property (p_oe) else $error("write without drive");
	property p_mode80; interface_mode_pins[0] |-> !enable; endproperty
	a_mode80: assert property (p_mode80) else $error("enable in 80 style");
	property p_split;
		data_bus_oe && mode_lsb_or_strap_pin && interface_mode_pins != 3'h2
			|-> data_bus_out[9:0] == 10'h000;
	endproperty
	a_split: assert property (p_split) else $error("split lanes not clear");
	// -------------------------------------------------------------
	// serial framing
	// -------------------------------------------------------------
	property p_sclk_idle; chip_select_n |-> serial_clock; endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("clock outside frame");
	property p_cs_sclk;
		$fell(chip_select_n) && interface_mode_pins == 3'h2 |=> $fell(serial_clock);
	endproperty
	a_cs_sclk: assert property (p_cs_sclk) else $error("first clock late");
	property p_sdi; serial_clock && $past(serial_clock) |-> $stable(serial_data_in); endproperty
	a_sdi: assert property (p_sdi) else $error("data moved in high phase");
endmodule : lcd_host_checker
bind lcd_host_ctrl lcd_host_checker u_chk (.aclk, .aresetn, .interface_mode_pins,
	.mode_lsb_or_strap_pin, .chip_select_n, .write_n, .enable, .data_bus_out, .data_bus_oe,
	.serial_clock, .serial_data_in);
`default_nettype wire

// ===== testbench/lcd_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model #(
	parameter logic [4:0] DEVICE_CODE = 5'h15, // arbitrary value
	parameter logic [15:0] RAM_INDEX = 16'h0022
) (
	input wire logic aclk,
	input wire logic [2:0] interface_mode_pins,
	input wire logic mode_lsb_or_strap_pin,
	input wire logic chip_select_n,
	input wire logic register_select,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic enable,
	input wire logic read_not_write,
	input wire logic [17:0] data_bus_out,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic [15:0] rd_word,
	output logic [17:0] data_bus_in,
	output logic serial_data_out,
	output logic [15:0] last_word,
	output logic last_rs,
	output logic [7:0] n_words
);
	logic p80, sel, rw, rs, wbeat, rbeat;
	logic [7:0] sh, hold, ob;
	logic [17:0] junk = 18'h15555;
	logic [15:0] index = 16'h0000;
	int nb, k, dum;
	initial n_words = 8'h00;
	initial serial_data_out = 1'h0;
	assign p80 = interface_mode_pins[0];
	// released bus shows a changing pattern, never the last value
	always @(posedge aclk) junk <= ~junk;
	task automatic put(input logic [15:0] w, input logic r);
		last_word = w;
		last_rs = r;
		n_words = n_words + 8'h01;
		if (!r) index = w;
	endtask : put
	always @(negedge chip_select_n) begin
		nb = 0;
		sel = 1'h0;
		wbeat = 1'h0;
		rbeat = 1'h0;
	end
	always @(posedge write_n or negedge enable) begin
		if (chip_select_n === 1'h0 && (p80 || !read_not_write)) begin
			if (mode_lsb_or_strap_pin && !wbeat) begin
				hold = data_bus_out[17:10];
				wbeat = 1'h1;
			end else begin
				put(mode_lsb_or_strap_pin ? {hold, data_bus_out[17:10]}
					: {data_bus_out[17:10], data_bus_out[8:1]}, register_select);
				wbeat = 1'h0;
			end
		end
	end
	always @(posedge read_n or negedge enable)
		if (chip_select_n === 1'h0 && (p80 || read_not_write)) rbeat = 1'h1;
	assign data_bus_in = (chip_select_n === 1'h0 && (p80 ? !read_n : enable && read_not_write))
		? (!mode_lsb_or_strap_pin ? {rd_word[15:8], 1'h0, rd_word[7:0], 1'h0}
		: {(rbeat ? rd_word[7:0] : rd_word[15:8]), 10'h000}) : junk;
	always @(posedge serial_clock) begin
		if (chip_select_n === 1'h0 && interface_mode_pins == 3'h2) begin
			sh = {sh[6:0], serial_data_in};
			nb = nb + 1;
			if (nb == 8) begin
				sel = sh[7:2] == {DEVICE_CODE, mode_lsb_or_strap_pin};
				rs = sh[1];
				rw = sh[0];
				dum = !rs || index != RAM_INDEX ? 2 : 4;
			end else if (sel && !rw && nb == 16) hold = sh;
			else if (sel && !rw && nb == 24) put({hold, sh}, rs);
		end
	end
	always @(negedge serial_clock) begin
		k = nb / 8 - 1;
		ob = k < dum ? 8'hA5 : k == dum ? rd_word[15:8] : rd_word[7:0];
		if (chip_select_n === 1'h0 && sel && rw && nb >= 8) serial_data_out = ob[7 - nb % 8];
		else serial_data_out = ~serial_data_out;
	end
endmodule : lcd_panel_model
`default_nettype wire

// ===== testbench/lcd_host_system_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_host_system_interface_tb;
	import lcd_host_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, frame_sync = 1'h1;
	logic [ADDR_W-1:0] awaddr = 5'h00, araddr = 5'h00;
	logic [DATA_W-1:0] wdata = 32'h0, rdata, v;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, mode_lsb_or_strap_pin, chip_select_n;
	logic register_select, write_n, read_n, enable, read_not_write, data_bus_oe;
	logic serial_clock, serial_data_in, serial_data_out, last_rs;
	logic [1:0] bresp, rresp, r;
	logic [2:0] interface_mode_pins;
	logic [DB_W-1:0] data_bus_out, data_bus_in;
	logic [15:0] rnd = 16'h0016, rd_word = 16'h0000, last_word;
	logic [7:0] n_words, n0;
	logic [3:0] modes [6] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h9, 4'hB};
	int fails = 0, n_checks = 0, cyc = 0;
	lcd_host_ctrl u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .interface_mode_pins, .mode_lsb_or_strap_pin, .chip_select_n, .register_select,
		.write_n, .read_n, .enable, .read_not_write, .data_bus_out, .data_bus_oe, .data_bus_in,
		.serial_clock, .serial_data_in, .serial_data_out, .frame_sync);
	lcd_panel_model u_dev (.aclk, .interface_mode_pins, .mode_lsb_or_strap_pin, .chip_select_n,
		.register_select, .write_n, .read_n, .enable, .read_not_write, .data_bus_out,
		.serial_clock, .serial_data_in, .rd_word, .data_bus_in, .serial_data_out, .last_word,
		.last_rs, .n_words);
	always #5 aclk = ~aclk;
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic pin_lsb(input logic [4:0] cfg);
		return cfg[3:1] == 3'h2 ? cfg[4] : cfg[0];
	endfunction : pin_lsb
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	// a hung handshake ends here rather than stalling the run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// bready and rready stay up once raised, so back-to-back calls never toggle them
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		r = bresp;
	endtask : axw
	task automatic axr(input logic [ADDR_W-1:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		v = rdata;
		r = rresp;
	endtask : axr
	task automatic wait_idle();
		repeat (2) @(posedge aclk);
		do axr(OFF_STATUS); while (v[ST_BUSY_BIT] !== 1'h0);
	endtask : wait_idle
	// fl holds pace, ram, read, register select from the top down
	task automatic cmd(input logic [15:0] d, input logic [3:0] fl);
		axw(OFF_COMMAND, {12'h000, fl, d});
		wait_idle();
	endtask : cmd
	task automatic rdchk(input logic [3:0] fl);
		rd_word <= lfsr(rd_word ^ rnd);
		cmd(16'h0000, fl);
		axr(OFF_READ_DATA);
		chk("read_data", v, {16'h0000, rd_word});
	endtask : rdchk
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		axr(OFF_CONFIG);
		chk("config", v, 32'h0);
		axr(OFF_ROW_CYCLES);
		chk("row_cycles", v, {16'h0000, ROW_CYCLES_RST});
		axr(OFF_STATUS);
		chk("status", v, 32'h2);
		axr(OFF_COMMAND);
		chk("command", v, 32'h0);
		axr(5'h14);
		chk("rresp_unmapped", {v[29:0], r}, {30'h0, RESP_SLVERR});
		axw(5'h18, 32'h1);
		chk("bresp_unmapped", r, RESP_SLVERR);
		$display("reset test done");
		foreach (modes[i]) begin
			axw(OFF_CONFIG, {28'h0, modes[i]});
			@(posedge aclk);
			chk("pins", {interface_mode_pins, mode_lsb_or_strap_pin}, modes[i]);
			rnd = lfsr(rnd);
			n0 = n_words;
			cmd(rnd, {3'h0, i[0]});
			chk("word", {last_rs, n_words - n0, last_word}, {i[0], 8'h01, rnd});
			rdchk({2'h0, 1'h1, i[0]});
		end
		$display("parallel test done");
		axw(OFF_CONFIG, 32'h14);
		@(posedge aclk);
		chk("strap", mode_lsb_or_strap_pin, pin_lsb(5'h14));
		n0 = n_words;
		cmd(16'h0022, 4'h0);
		rnd = lfsr(rnd);
		cmd(rnd, 4'h1);
		chk("serial_word", {last_rs, n_words - n0, last_word}, {1'h1, 8'h02, rnd});
		rdchk(4'h7);
		rdchk(4'h2);
		cmd(16'h0007, 4'h0);
		rdchk(4'h3);
		$display("serial test done");
		axw(OFF_CONFIG, 32'h2);
		axw(OFF_ROW_CYCLES, 32'h28);
		frame_sync <= 1'h0;
		repeat (6) @(posedge aclk);
		axr(OFF_STATUS);
		chk("open", v[ST_OPEN_BIT], 1'h0);
		n0 = n_words;
		axw(OFF_COMMAND, {12'h000, 4'h9, rnd});
		repeat (20) @(posedge aclk);
		chk("held", chip_select_n, 1'h1);
		wait_idle();
		chk("paced_word", {n_words - n0, last_word}, {8'h01, rnd});
		frame_sync <= 1'h1;
		$display("frame sync test done");
		finish_test();
	end
endmodule : lcd_host_system_interface_tb
`default_nettype wire
